// file: rtl/art_timer.sv
// PWM auto-reload timer with capture channels and register port
//
// The strobed register port and the placing of the registers are this design's own decisions.
`include "art_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module art_timer #(
  parameter int CHANNELS = 4,
  parameter int CAPTURES = 2
) (
  input  wire logic                   clock,
  input  wire logic                   resetn,
  input  wire art_pkg::art_bus_req_t  bus,
  output logic [7:0]                  rdata,
  input  wire logic                   halt_mode,
  input  wire logic                   external_clock_in,
  input  wire logic [CAPTURES-1:0]    capture_input_pin,
  output art_pkg::art_pwm_pins_t      pwm_pins,
  output logic                        overflow_irq,
  output logic [CAPTURES-1:0]         capture_irq,
  output logic                        halt_wakeup
);
  import art_pkg::*;

  logic [7:0]          duty_value [CHANNELS];
  logic [7:0]          compare_shadow [CHANNELS];
  logic [7:0]          capture_value [CAPTURES];
  logic [7:0]          pwm_output_control;
  logic [7:0]          auto_reload_value;
  logic                ext_clock_select;
  logic [2:0]          count_divider_select;
  logic                counter_run_enable;
  logic                overflow_irq_enable;
  logic                overflow_flag;
  logic [CAPTURES-1:0] capture_edge_select;
  logic [CAPTURES-1:0] capture_irq_enable;
  logic [CAPTURES-1:0] capture_flag;
  logic [7:0]          counter;
  logic [6:0]          prescaler;
  logic                ext_q;
  logic [CAPTURES-1:0] cap_q;
  logic [CHANNELS-1:0] pwm_level;

  // Decode
  wire wr_csr   = bus.wr && bus.addr == `ART_OFF_CSR;
  wire wr_car   = bus.wr && bus.addr == `ART_OFF_CAR;
  wire wr_arr   = bus.wr && bus.addr == `ART_OFF_ARR;
  wire wr_pwm_output_control = bus.wr && bus.addr == `ART_OFF_PWM_OUTPUT_CONTROL;
  wire wr_iccsr = bus.wr && bus.addr == `ART_OFF_ICCSR;
  wire rd_csr   = bus.rd && bus.addr == `ART_OFF_CSR;
  wire rd_icr1  = bus.rd && bus.addr == `ART_OFF_ICR1;
  wire rd_icr2  = bus.rd && bus.addr == `ART_OFF_ICR2;

  // Source clock; the external input is taken as a level and edge-detected
  wire ext_rise = external_clock_in && !ext_q;
  art_src_t src;
  assign src = !counter_run_enable ? ART_SRC_STOP :
               (ext_clock_select ? ART_SRC_EXT : ART_SRC_CPU);
  // The external source is gated in halt so no spurious count can slip in
  wire input_tick = (src == ART_SRC_CPU) ||
                    (src == ART_SRC_EXT && ext_rise && !halt_mode);
  wire [7:0] next_prescaler_full = {1'b0, prescaler} + 8'h01;
  wire [6:0] next_prescaler = next_prescaler_full[6:0];
  // Tap n fires when the low n bits wrap to zero
  wire [7:0] tap_mask = (8'h01 << count_divider_select) - 8'h01;
  wire counter_tick = input_tick &&
                      ((next_prescaler_full & tap_mask) == 8'h00);
  wire overflow = counter_tick && counter == `ART_COUNT_MAX;
  wire force_load = wr_csr && bus.wdata[`ART_CSR_FORCE_RELOAD] && bus.wdata[`ART_CSR_TCE];

  // Prescaler: cleared by any counter initialisation, frozen while stopped
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      prescaler <= 7'h00;
    else if (wr_car || force_load)
      prescaler <= 7'h00;
    else if (input_tick)
      prescaler <= next_prescaler;
  end

  // Counter: an overflow reloads it but leaves the prescaler phase alone
  wire [7:0] counter_inc = counter + 8'h01;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      counter <= 8'h00;
    else if (wr_car)
      counter <= bus.wdata;
    else if (force_load)
      counter <= auto_reload_value;
    else if (overflow)
      counter <= auto_reload_value;
    else if (counter_tick)
      counter <= counter_inc;
  end

  // Event input history; resets to the idle low level so no false edge follows
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ext_q <= 1'b0;
    else
      ext_q <= external_clock_in;
  end

  // Clock selection fields
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_clock_select     <= 1'b0;
      count_divider_select <= 3'h0;
    end
    else if (wr_csr)
    begin
      ext_clock_select     <= bus.wdata[`ART_CSR_EXT_CLOCK_SELECT];
      count_divider_select <= bus.wdata[`ART_CSR_CC_HI:`ART_CSR_CC_LO];
    end
  end

  // Run and interrupt enables; the reload request is acted on only when TCE is written 1 with it, never stored
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      counter_run_enable  <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end
    else if (wr_csr)
    begin
      counter_run_enable  <= bus.wdata[`ART_CSR_TCE];
      overflow_irq_enable <= bus.wdata[`ART_CSR_OIE];
    end
  end

  // Reload value, used at the next wrap and by a forced reload
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      auto_reload_value <= `ART_RESET_BYTE;
    else if (wr_arr)
      auto_reload_value <= bus.wdata;
  end

  // Output enables in the high nibble, polarities in the low nibble
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      pwm_output_control <= `ART_RESET_BYTE;
    else if (wr_pwm_output_control)
      pwm_output_control <= bus.wdata;
  end

  // Capture configuration; the flags are owned by the capture channels
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      capture_edge_select <= '0;
      capture_irq_enable  <= '0;
    end
    else if (wr_iccsr)
    begin
      capture_edge_select <= bus.wdata[`ART_ICC_CS_LO +: CAPTURES];
      capture_irq_enable  <= bus.wdata[`ART_ICC_CIE_LO +: CAPTURES];
    end
  end

  // Overflow flag: the set wins over the clearing read
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      overflow_flag <= 1'b0;
    else if (overflow)
      overflow_flag <= 1'b1;
    else if (rd_csr)
      overflow_flag <= 1'b0;
  end
  assign overflow_irq = overflow_flag && overflow_irq_enable;

  // PWM channels
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_pwm
      wire wr_duty = bus.wr && bus.addr == 4'(`ART_OFF_DUTY0 - ch);
      wire polarity = pwm_output_control[ch];
      wire compare_hit = counter_tick && counter == compare_shadow[ch];
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
          duty_value[ch] <= `ART_RESET_BYTE;
        else if (wr_duty)
          duty_value[ch] <= bus.wdata;
      end
      // Shadow moves only at a wrap, so a duty write never cuts a period short
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
          compare_shadow[ch] <= `ART_RESET_BYTE;
        else if (overflow && !halt_mode)
          compare_shadow[ch] <= duty_value[ch];
      end
      // In halt the level freezes; the pin changes only when its polarity bit is written
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
          pwm_level[ch] <= 1'b1;
        else if (halt_mode)
          pwm_level[ch] <= pwm_level[ch];
        else if (overflow)
          pwm_level[ch] <= 1'b1;
        else if (compare_hit)
          pwm_level[ch] <= 1'b0;
      end
      // Polarity flip takes effect at once, as software expects
      assign pwm_pins.out[ch] = pwm_level[ch] ^ polarity;
      assign pwm_pins.oe[ch]  = pwm_output_control[4 + ch];
    end
  endgenerate

  // Capture channels
  genvar cp;
  generate
    for (cp = 0; cp < CAPTURES; cp++)
    begin : g_cap
      wire rd_icr = (cp == 0) ? rd_icr1 : rd_icr2;
      wire pin_rise = capture_input_pin[cp] && !cap_q[cp];
      wire pin_fall = !capture_input_pin[cp] && cap_q[cp];
      wire edge_hit = capture_edge_select[cp] ? pin_rise : pin_fall;
      // A read in the cycle of a new edge frees the register for that edge
      wire capture_take = edge_hit && (!capture_flag[cp] || rd_icr);
      // Resets low: with the falling-edge default a low history cannot fire
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
          cap_q[cp] <= 1'b0;
        else
          cap_q[cp] <= capture_input_pin[cp];
      end
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
          capture_value[cp] <= `ART_RESET_BYTE;
        else if (capture_take)
          capture_value[cp] <= counter;
      end
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
          capture_flag[cp] <= 1'b0;
        else if (capture_take)
          capture_flag[cp] <= 1'b1;
        else if (rd_icr)
          capture_flag[cp] <= 1'b0;
      end
      assign capture_irq[cp] = capture_flag[cp] && capture_irq_enable[cp];
    end
  endgenerate

  // Wakeup needs an enabled capture; a masked edge only sets its flag
  assign halt_wakeup = halt_mode && |capture_irq;

  // Read words and selection; unmapped indexes read zero
  wire [7:0] csr_word = {ext_clock_select, count_divider_select,
                         counter_run_enable, 1'b0, overflow_irq_enable, overflow_flag};
  wire [7:0] iccsr_word = {2'b00, capture_edge_select,
                           capture_irq_enable, capture_flag};
  wire sel_duty3 = bus.addr == `ART_OFF_DUTY3;
  wire sel_duty2 = bus.addr == `ART_OFF_DUTY2;
  wire sel_duty1 = bus.addr == `ART_OFF_DUTY1;
  wire sel_duty0 = bus.addr == `ART_OFF_DUTY0;
  wire sel_pwm_output_control = bus.addr == `ART_OFF_PWM_OUTPUT_CONTROL;
  wire sel_csr   = bus.addr == `ART_OFF_CSR;
  wire sel_car   = bus.addr == `ART_OFF_CAR;
  wire sel_arr   = bus.addr == `ART_OFF_ARR;
  wire sel_iccsr = bus.addr == `ART_OFF_ICCSR;
  wire sel_icr1  = bus.addr == `ART_OFF_ICR1;
  wire sel_icr2  = bus.addr == `ART_OFF_ICR2;
  wire [7:0] next_rdata = ({8{sel_duty3}} & duty_value[3]) |
                          ({8{sel_duty2}} & duty_value[2]) |
                          ({8{sel_duty1}} & duty_value[1]) |
                          ({8{sel_duty0}} & duty_value[0]) |
                          ({8{sel_pwm_output_control}} & pwm_output_control) |
                          ({8{sel_csr}}   & csr_word) |
                          ({8{sel_car}}   & counter) |
                          ({8{sel_arr}}   & auto_reload_value) |
                          ({8{sel_iccsr}} & iccsr_word) |
                          ({8{sel_icr1}}  & capture_value[0]) |
                          ({8{sel_icr2}}  & capture_value[1]);

  // Data stands one cycle after the strobe and reads zero otherwise

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (bus.rd)
      rdata <= next_rdata;
    else
      rdata <= 8'h00;
  end

endmodule // art_timer

`default_nettype wire

// file: rtl/art_regs.svh
// Register offsets, field positions and reset values of the reload timer block
`ifndef ART_REGS_SVH
`define ART_REGS_SVH

`define ART_ADDR_W        4
`define ART_OFF_DUTY3     4'h3
`define ART_OFF_DUTY2     4'h4
`define ART_OFF_DUTY1     4'h5
`define ART_OFF_DUTY0     4'h6
`define ART_OFF_PWM_OUTPUT_CONTROL     4'h7
`define ART_OFF_CSR       4'h8
`define ART_OFF_CAR       4'h9
`define ART_OFF_ARR       4'ha
`define ART_OFF_ICCSR     4'hb
`define ART_OFF_ICR1      4'hc
`define ART_OFF_ICR2      4'hd
`define ART_CSR_EXT_CLOCK_SELECT      7
`define ART_CSR_CC_HI     6
`define ART_CSR_CC_LO     4
`define ART_CSR_TCE       3
`define ART_CSR_FORCE_RELOAD      2
`define ART_CSR_OIE       1
`define ART_CSR_OVF       0
`define ART_ICC_CS_LO     4
`define ART_ICC_CIE_LO    2
`define ART_ICC_CF_LO     0
`define ART_RESET_BYTE    8'h00
`define ART_COUNT_MAX     8'hff

`endif

// file: rtl/art_pkg.sv
// Types shared by the reload timer block
package art_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } art_bus_req_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } art_pwm_pins_t;

  typedef enum logic [1:0] {
    ART_SRC_STOP = 2'b00,
    ART_SRC_CPU  = 2'b01,
    ART_SRC_EXT  = 2'b10
  } art_src_t;
endpackage

// file: dv/art_chk.sv
// Port assertions for the reload timer
`timescale 1ns/1ps
`default_nettype none
module art_chk #(
  parameter int CAPTURES = 2
) (
  input wire logic                   clock,
  input wire logic                   resetn,
  input wire art_pkg::art_bus_req_t  bus,
  input wire logic [7:0]             rdata,
  input wire logic                   halt_mode,
  input wire logic                   external_clock_in,
  input wire logic [CAPTURES-1:0]    capture_input_pin,
  input wire art_pkg::art_pwm_pins_t pwm_pins,
  input wire logic                   overflow_irq,
  input wire logic [CAPTURES-1:0]    capture_irq,
  input wire logic                   halt_wakeup
);
  import art_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  property p_oe;
    bus.wr && bus.addr == 4'h7 |=> pwm_pins.oe == $past(bus.wdata[7:4]);
  endproperty
  a_oe: assert property (p_oe) else $error("enable mismatch");
  property p_force_reload;
    bus.rd && bus.addr == 4'h8 |=> !rdata[2];
  endproperty
  a_force_reload: assert property (p_force_reload) else $error("reload bit read");
  property p_wake;
    halt_wakeup == (halt_mode && (|capture_irq));
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup wrong");
  property p_cap_hold;
    capture_irq[0] && !(bus.wr && bus.addr == 4'hb) && !(bus.rd && bus.addr == 4'hc)
      |=> capture_irq[0];
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture dropped");
  property p_ovf_hold;
    overflow_irq && !((bus.wr || bus.rd) && bus.addr == 4'h8) |=> overflow_irq;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow dropped");
  property p_cie_off;
    bus.wr && bus.addr == 4'hb && !bus.wdata[2] |=> !capture_irq[0];
  endproperty
  a_cie_off: assert property (p_cie_off) else $error("masked request");
  property p_halt;
    halt_mode && !bus.wr |=> $stable(pwm_pins.out);
  endproperty
  a_halt: assert property (p_halt) else $error("pwm moved in halt");
  property p_rst;
    disable iff (1'b0) !resetn |-> pwm_pins.oe == 4'h0 && rdata == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule // art_chk
`default_nettype wire

// file: dv/art_pins.sv
// Pin model: event source and capture signals
`timescale 1ns/1ps
`default_nettype none
module art_pins (
  input  wire logic  clock,
  output logic       external_clock_in,
  output logic [1:0] capture_input_pin
);
  initial
  begin
    external_clock_in = 1'b0;
    capture_input_pin = 2'b11;
  end
  // Whole pulses only; the line rests low between bursts
  task automatic burst(input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(posedge clock);
      external_clock_in <= 1'b1;
      repeat (half) @(posedge clock);
      external_clock_in <= 1'b0;
    end
  endtask
  task automatic pin(input int ch, input logic v);
    @(posedge clock);
    capture_input_pin[ch] <= v;
  endtask
endmodule // art_pins
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the reload timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import art_pkg::*;
  logic          clock;
  logic          resetn;
  art_bus_req_t  bus;
  logic [7:0]    rdata;
  logic          halt_mode;
  logic          ext_clk;
  logic [1:0]    cap_pin;
  art_pwm_pins_t pwm_pins;
  logic          overflow_irq;
  logic [1:0]    capture_irq;
  logic          halt_wakeup;
  logic [7:0]    d;
  int            err_count;
  int            tests_run;
  art_timer i_dut (.clock(clock), .resetn(resetn), .bus(bus), .rdata(rdata),
    .halt_mode(halt_mode), .external_clock_in(ext_clk), .capture_input_pin(cap_pin),
    .pwm_pins(pwm_pins), .overflow_irq(overflow_irq), .capture_irq(capture_irq),
    .halt_wakeup(halt_wakeup));
  art_pins i_pins (.clock(clock), .external_clock_in(ext_clk), .capture_input_pin(cap_pin));
  always #2 clock = ~clock;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '{a, v, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [3:0] a);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b0};
    #1 d = rdata;
  endtask
  // Eight cycles, two whole periods at a reload of fc, so the count does not depend on phase
  task automatic high_cnt(input logic [7:0] exp);
    logic [7:0] c;
    c = 8'h00;
    repeat (8)
    begin
      @(posedge clock);
      #1 c += {7'h0, pwm_pins.out[0]};
    end
    chk(c, exp);
  endtask
  task automatic t_reset();
    for (int a = 0; a < 16; a++)
    begin
      rd(a[3:0]);
      chk(d, 8'h00);
    end
  endtask
  task automatic t_prescale();
    for (int n = 0; n < 8; n++)
    begin
      wr(4'h9, 8'h10);
      wr(4'h8, {1'b0, n[2:0], 4'h8});
      repeat (3 * (1 << n) - 1) @(posedge clock);
      wr(4'h8, 8'h00);
      rd(4'h9);
      chk(d, 8'h13);
    end
  endtask
  task automatic t_event();
    wr(4'ha, 8'hfd);
    wr(4'h8, 8'h8e);
    i_pins.burst(2, 1);
    repeat (6) @(posedge clock);
    chk({7'h0, overflow_irq}, 8'h00);
    i_pins.burst(1, 3);
    repeat (6) @(posedge clock);
    chk({7'h0, overflow_irq}, 8'h01);
    rd(4'h8);
    chk(d, 8'h8b);
    chk({7'h0, overflow_irq}, 8'h00);
    rd(4'h9);
    chk(d, 8'hfd);
  endtask
  task automatic t_pwm();
    wr(4'h6, 8'hfe);
    wr(4'h7, 8'h10);
    #1 chk({4'h0, pwm_pins.oe}, 8'h01);
    wr(4'ha, 8'hfc);
    wr(4'h8, 8'h0c);
    repeat (12) @(posedge clock);
    high_cnt(8'h06);
    wr(4'h7, 8'h11);
    high_cnt(8'h02);
    halt_mode <= 1'b1;
    @(posedge clock);
    #1 d = {4'h0, pwm_pins.out};
    repeat (8) @(posedge clock);
    #1 chk({4'h0, pwm_pins.out}, d);
    halt_mode <= 1'b0;
    wr(4'ha, 8'h00);
    wr(4'h6, 8'hff);
    wr(4'h7, 8'h10);
    repeat (300) @(posedge clock);
    high_cnt(8'h08);
    wr(4'h7, 8'h11);
    high_cnt(8'h00);
  endtask
  task automatic t_capture();
    wr(4'h8, 8'h00);
    wr(4'h9, 8'h42);
    wr(4'hb, 8'h14);
    i_pins.pin(0, 1'b0);
    repeat (4) @(posedge clock);
    chk({6'h0, capture_irq}, 8'h00);
    i_pins.pin(0, 1'b1);
    repeat (4) @(posedge clock);
    chk({6'h0, capture_irq}, 8'h01);
    wr(4'h9, 8'h55);
    i_pins.pin(0, 1'b0);
    i_pins.pin(0, 1'b1);
    repeat (4) @(posedge clock);
    rd(4'hc);
    chk(d, 8'h42);
    chk({6'h0, capture_irq}, 8'h00);
    halt_mode <= 1'b1;
    wr(4'hb, 8'h08);
    i_pins.pin(1, 1'b0);
    repeat (4) @(posedge clock);
    chk({7'h0, halt_wakeup}, 8'h01);
    rd(4'hd);
    chk(d, 8'h55);
    halt_mode <= 1'b0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    resetn = 1'b0;
    bus = '0;
    halt_mode = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_prescale();
    t_event();
    t_pwm();
    t_capture();
    conclude();
  end
  // Whole run needs about 1200 cycles
  initial
  begin
    #40000;
    err_count++;
    conclude();
  end
endmodule // tb
bind art_timer art_chk #(.CAPTURES(CAPTURES)) i_chk (.clock(clock), .resetn(resetn),
  .bus(bus), .rdata(rdata), .halt_mode(halt_mode), .external_clock_in(external_clock_in),
  .capture_input_pin(capture_input_pin), .pwm_pins(pwm_pins), .overflow_irq(overflow_irq),
  .capture_irq(capture_irq), .halt_wakeup(halt_wakeup));
`default_nettype wire
